// ### rtl/tpes_consts.svh
// Timing, reset and encoding constants for the timer output and slave logic.
// Assumes inclusion by the package and the top module only.
`ifndef TPES_CONSTS_SVH
`define TPES_CONSTS_SVH
`define TPES_CLK_MHZ 50
`define TPES_CNT_W 16
`define TPES_CNT_RST 16'h0000
`define TPES_OM_FROZEN 3'h0
`define TPES_OM_MATCH_ACT 3'h1
`define TPES_OM_MATCH_INACT 3'h2
`define TPES_OM_TOGGLE 3'h3
`define TPES_OM_FORCE_INACT 3'h4
`define TPES_OM_FORCE_ACT 3'h5
`define TPES_OM_PWM1 3'h6
`define TPES_OM_PWM2 3'h7
`define TPES_SM_OFF 3'h0
`define TPES_SM_ENC1 3'h1
`define TPES_SM_ENC2 3'h2
`define TPES_SM_ENC3 3'h3
`define TPES_SM_RESET 3'h4
`define TPES_SM_GATED 3'h5
`define TPES_SM_TRIG 3'h6
`define TPES_DIR_OUT 2'h0
`define TPES_CM_EDGE 2'h0
`define TPES_FLT_MAX 4'hF
`endif

// ### rtl/tpes_pkg.sv
// Types shared by the timer output, encoder and slave logic.
// Assumes tpes_consts.svh is on the include path.
`include "tpes_consts.svh"
package tpes_pkg;
  typedef enum logic [1:0] {tpes_cnt_up, tpes_cnt_down, tpes_cnt_center} tpes_cmode_t;
  typedef struct packed {
    logic [2:0] compare_output_mode_field;
    logic channel_polarity_bit;
    logic [1:0] channel_direction_select;
    logic channel_irq_enable;
    logic [15:0] channel_compare_value;
  } tpes_chan_cfg_t;
  typedef struct packed {
    logic update_irq_enable;
    logic trigger_irq_enable;
    logic update_dma_enable;
    logic trigger_dma_enable;
    logic channel_dma_select;
  } tpes_evt_cfg_t;
endpackage

// ### rtl/tpes_timer.sv
// Timer time base, two compare/capture channels, encoder and slave-mode control.
// Assumes config ports are static or change from the same clock; pins are async.
`timescale 1ns/1ps
`include "tpes_consts.svh"

module tpes_timer
#(
  parameter int CNT_W = `TPES_CNT_W
)
(
  input wire logic clock, // 50 MHz kernel clock
  input wire logic nrst, // Async reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic counter_enable, // Software run request
  input wire logic single_pulse_enable, // Stop at next update
  input wire tpes_pkg::tpes_cmode_t count_mode, // Up, down or center-aligned
  input wire logic soft_direction_down, // Loads the direction bit only while stopped in up mode
  input wire logic [CNT_W-1:0] auto_reload_value, // Period
  input wire logic [15:0] prescaler_value, // Divide by value plus one
  input wire logic [2:0] slave_function_select, // Encoder or slave mode
  input wire logic trigger_from_input_two, // Trigger source select
  input wire logic pwm_input_mode, // Channel two follows channel one
  input wire logic [3:0] input_one_filter_field, // Input one filter length
  input wire logic [3:0] input_two_filter_field, // Input two filter length
  input wire tpes_pkg::tpes_chan_cfg_t ch1_cfg, // Channel one config
  input wire tpes_pkg::tpes_chan_cfg_t ch2_cfg, // Channel two config
  input wire tpes_pkg::tpes_evt_cfg_t evt_cfg, // Event enables
  input wire logic [3:0] flag_clear, // Clear: ch1, ch2, update, trigger
  input wire logic channel_one_pin_in, // Encoder input one pin
  input wire logic channel_two_pin_in, // Encoder input two pin
  output logic channel_one_pin_out, // Channel one output level
  output logic channel_one_pin_oe, // High while channel one drives
  output logic channel_two_pin_out, // Channel two output level
  output logic channel_two_pin_oe, // High while channel two drives
  output logic [CNT_W-1:0] counter_value, // Counter
  output logic count_direction_bit, // 1 while counting down
  output logic counter_running, // Counter enabled state
  output logic [3:0] event_flags, // Sticky: ch1, ch2, update, trigger
  output logic irq, // Combined interrupt
  output logic [1:0] dma_req // Update and channel DMA requests
);
  import tpes_pkg::*;

  logic [1:0] sync1_r, sync2_r, prev_r, filt_r, filt_nxt;
  logic [3:0] fcnt1_r, fcnt1_nxt, fcnt2_r, fcnt2_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [15:0] psc_r, psc_nxt;
  logic dir_r, dir_nxt, run_r, run_nxt, trg_prev_r;
  logic [1:0] ref_r, ref_nxt;
  logic [3:0] flag_r, flag_nxt;
  logic irq_r, irq_nxt;
  logic [1:0] dma_r, dma_nxt;
  logic [1:0] in_pol, rise, fall;
  logic trig_lvl, trig_rise, enc_mode, tick, update_ev, enc_step;
  tpes_chan_cfg_t ch [2];

  assign ch[0] = ch1_cfg;
  assign ch[1] = ch2_cfg;

  // Two-stage sync before anything looks at the pins
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      prev_r <= 2'h0;
      filt_r <= 2'h0;
      fcnt1_r <= 4'h0;
      fcnt2_r <= 4'h0;
      trg_prev_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_r <= {channel_two_pin_in, channel_one_pin_in};
      sync2_r <= sync1_r;
      filt_r <= filt_nxt;
      fcnt1_r <= fcnt1_nxt;
      fcnt2_r <= fcnt2_nxt;
      prev_r <= filt_r;
      trg_prev_r <= trig_lvl;
    end
  end

  // Filter: a new level must persist for the filter-field count plus one cycles
  always_comb
  begin
    filt_nxt = filt_r;
    fcnt1_nxt = 4'h0;
    fcnt2_nxt = 4'h0;
    if (sync2_r[0] != filt_r[0])
    begin
      if (fcnt1_r >= input_one_filter_field)
        filt_nxt[0] = sync2_r[0];
      else
        fcnt1_nxt = fcnt1_r + 4'h1;
    end
    if (sync2_r[1] != filt_r[1])
    begin
      if (fcnt2_r >= input_two_filter_field)
        filt_nxt[1] = sync2_r[1];
      else
        fcnt2_nxt = fcnt2_r + 4'h1;
    end
  end

  // Input polarity; channel two reads input two, but captures on input one in PWM input mode
  assign in_pol[0] = filt_r[0] ^ ch1_cfg.channel_polarity_bit;
  assign in_pol[1] = filt_r[1] ^ ch2_cfg.channel_polarity_bit;
  assign rise = filt_r & ~prev_r;
  assign fall = ~filt_r & prev_r;
  assign trig_lvl = trigger_from_input_two ? in_pol[1] : in_pol[0];
  assign trig_rise = trig_lvl & ~trg_prev_r;
  assign enc_mode = (slave_function_select == `TPES_SM_ENC1) ||
                    (slave_function_select == `TPES_SM_ENC2) ||
                    (slave_function_select == `TPES_SM_ENC3);
  assign tick = (psc_r == prescaler_value);

  // Time base, encoder and slave control
  always_comb
  begin
    logic e1, e2, p1, p2;
    e1 = (rise[0] | fall[0]) && (slave_function_select != `TPES_SM_ENC2);
    e2 = (rise[1] | fall[1]) && (slave_function_select != `TPES_SM_ENC1);
    p1 = in_pol[0];
    p2 = in_pol[1];
    cnt_nxt = cnt_r;
    psc_nxt = psc_r;
    dir_nxt = dir_r;
    run_nxt = run_r;
    update_ev = 1'b0;
    enc_step = 1'b0;
    // Trigger mode: hardware sets the run state, so software enable is not needed
    if (slave_function_select == `TPES_SM_TRIG)
    begin
      if (trig_rise)
        run_nxt = 1'b1;
    end
    else if (!counter_enable)
      run_nxt = 1'b0;
    else if (!run_r && !single_pulse_enable)
      run_nxt = 1'b1;
    else if (!run_r && single_pulse_enable && !flag_r[2])
      run_nxt = 1'b1;
    if (enc_mode)
    begin
      // Direction recomputed on every qualified edge, never written by software
      if (e1)
      begin
        enc_step = 1'b1;
        dir_nxt = rise[0] ? p2 : ~p2;
      end
      else if (e2)
      begin
        enc_step = 1'b1;
        dir_nxt = rise[1] ? ~p1 : p1;
      end
      if (enc_step && run_r)
      begin
        if (dir_nxt)
          cnt_nxt = (cnt_r == '0) ? auto_reload_value : cnt_r - 1'b1;
        else
          cnt_nxt = (cnt_r >= auto_reload_value) ? '0 : cnt_r + 1'b1;
      end
    end
    else if ((slave_function_select == `TPES_SM_RESET) && trig_rise)
    begin
      cnt_nxt = (count_mode == tpes_cnt_down) ? auto_reload_value : '0;
      psc_nxt = 16'h0000;
      update_ev = 1'b1;
    end
    else if (run_r && !((slave_function_select == `TPES_SM_GATED) && !trig_lvl))
    begin
      psc_nxt = tick ? 16'h0000 : psc_r + 16'h0001;
      if (tick)
      begin
        if (count_mode == tpes_cnt_up || (count_mode == tpes_cnt_center && !dir_r))
        begin
          dir_nxt = 1'b0;
          if (cnt_r >= auto_reload_value)
          begin
            // Overrun
            cnt_nxt = (count_mode == tpes_cnt_center) ? cnt_r - 1'b1 : '0;
            dir_nxt = (count_mode == tpes_cnt_center);
            update_ev = 1'b1;
          end
          else
            cnt_nxt = cnt_r + 1'b1;
        end
        else
        begin
          dir_nxt = 1'b1;
          if (cnt_r == '0)
          begin
            // Underrun
            cnt_nxt = (count_mode == tpes_cnt_center) ? cnt_r + 1'b1 : auto_reload_value;
            dir_nxt = (count_mode != tpes_cnt_center);
            update_ev = 1'b1;
          end
          else
            cnt_nxt = cnt_r - 1'b1;
        end
      end
    end
    if (count_mode == tpes_cnt_up && !enc_mode && !run_r)
      dir_nxt = soft_direction_down;
    if (update_ev && single_pulse_enable)
      run_nxt = 1'b0;
  end

  // Output references and events, one per channel
  always_comb
  begin
    logic below, match;
    logic [1:0] cap_ev;
    ref_nxt = ref_r;
    flag_nxt = flag_r & ~flag_clear;
    below = 1'b0;
    match = 1'b0;
    cap_ev = 2'h0;
    for (int i = 0; i < 2; i++)
    begin
      below = cnt_r < ch[i].channel_compare_value;
      match = (cnt_r == ch[i].channel_compare_value) && run_r;
      if (ch[i].channel_direction_select == `TPES_DIR_OUT)
      begin
        if (match)
          cap_ev[i] = 1'b1;
        if (!(single_pulse_enable && !run_r))
        begin
          case (ch[i].compare_output_mode_field)
            `TPES_OM_MATCH_ACT: if (match) ref_nxt[i] = 1'b1;
            `TPES_OM_MATCH_INACT: if (match) ref_nxt[i] = 1'b0;
            `TPES_OM_TOGGLE: if (match) ref_nxt[i] = ~ref_r[i];
            `TPES_OM_FORCE_INACT: ref_nxt[i] = 1'b0;
            `TPES_OM_FORCE_ACT: ref_nxt[i] = 1'b1;
            `TPES_OM_PWM1: ref_nxt[i] = below;
            `TPES_OM_PWM2: ref_nxt[i] = ~below;
            default: ref_nxt[i] = ref_r[i];
          endcase
        end
      end
      else
      begin
        // Capture on active edge; channel two opposite edge in PWM input
        if (i == 0)
          cap_ev[i] = rise[0] ^ (fall[0] & ch1_cfg.channel_polarity_bit) ^
                      (rise[0] & ch1_cfg.channel_polarity_bit);
        else if (pwm_input_mode)
          cap_ev[i] = ch1_cfg.channel_polarity_bit ? rise[0] : fall[0];
        else
          cap_ev[i] = ch2_cfg.channel_polarity_bit ? fall[1] : rise[1];
      end
      if (cap_ev[i])
        flag_nxt[i] = 1'b1;
    end
    // Sets win over same-cycle clears
    if (update_ev)
      flag_nxt[2] = 1'b1;
    if (trig_rise && slave_function_select[2])
      flag_nxt[3] = 1'b1;
    irq_nxt = (flag_nxt[0] & ch1_cfg.channel_irq_enable) |
              (flag_nxt[1] & ch2_cfg.channel_irq_enable) |
              (flag_nxt[2] & evt_cfg.update_irq_enable) |
              (flag_nxt[3] & evt_cfg.trigger_irq_enable);
    dma_nxt[0] = update_ev & evt_cfg.update_dma_enable;
    dma_nxt[1] = (|cap_ev & evt_cfg.channel_dma_select) |
                 (trig_rise & evt_cfg.trigger_dma_enable);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= `TPES_CNT_RST;
      psc_r <= 16'h0000;
      dir_r <= 1'b0;
      run_r <= 1'b0;
      ref_r <= 2'h0;
      flag_r <= 4'h0;
      irq_r <= 1'b0;
      dma_r <= 2'h0;
      channel_one_pin_out <= 1'b0;
      channel_two_pin_out <= 1'b0;
      channel_one_pin_oe <= 1'b0;
      channel_two_pin_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_r <= cnt_nxt;
      psc_r <= psc_nxt;
      dir_r <= dir_nxt;
      run_r <= run_nxt;
      ref_r <= ref_nxt;
      flag_r <= flag_nxt;
      irq_r <= irq_nxt;
      dma_r <= dma_nxt;
      channel_one_pin_out <= ref_nxt[0] ^ ch1_cfg.channel_polarity_bit;
      channel_two_pin_out <= ref_nxt[1] ^ ch2_cfg.channel_polarity_bit;
      channel_one_pin_oe <= (ch1_cfg.channel_direction_select == `TPES_DIR_OUT);
      channel_two_pin_oe <= (ch2_cfg.channel_direction_select == `TPES_DIR_OUT);
    end
  end

  assign counter_value = cnt_r;
  assign count_direction_bit = dir_r;
  assign counter_running = run_r;
  assign event_flags = flag_r;
  assign irq = irq_r;
  assign dma_req = dma_r;
endmodule // tpes_timer

// ### sim/tpes_timer_asserts.sv
// Port checks for tpes_timer.
// Assumes a bind to tpes_timer; watches its ports only.
`timescale 1ns/1ps
module tpes_timer_asserts
#(
  parameter int CNT_W = 16
)
(
  input wire logic clock, // Clock
  input wire logic nrst, // Reset
  input wire logic clk_en, // Run
  input wire logic counter_enable, // Start
  input wire logic single_pulse_enable, // One shot
  input wire tpes_pkg::tpes_cmode_t count_mode, // Mode
  input wire logic [CNT_W-1:0] auto_reload_value, // Period
  input wire logic [15:0] prescaler_value, // Divider
  input wire logic [2:0] slave_function_select, // Slave
  input wire tpes_pkg::tpes_chan_cfg_t ch1_cfg, // Channel
  input wire logic [3:0] flag_clear, // Clears
  input wire logic channel_one_pin_out, // Pin
  input wire logic channel_one_pin_oe, // Enable
  input wire logic [CNT_W-1:0] counter_value, // Count
  input wire logic counter_running, // Running
  input wire logic [3:0] event_flags, // Flags
  input wire logic irq, // Interrupt
  input wire logic [1:0] dma_req // DMA
);
  import tpes_pkg::*;
  logic [2:0] om;
  logic [3:0] keep;
  logic up_run, pwm_run, frc, pwm_lvl;
  assign om = ch1_cfg.compare_output_mode_field;
  assign keep = event_flags & ~flag_clear;
  assign up_run = clk_en && counter_running && counter_enable && !single_pulse_enable
    && prescaler_value == 16'h0000 && slave_function_select == 3'h0 && count_mode == tpes_cnt_up;
  assign pwm_run = clk_en && counter_running && !single_pulse_enable && om[2:1] == 2'h3
    && ch1_cfg.channel_direction_select == 2'h0;
  assign frc = clk_en && om[2:1] == 2'h2 && ch1_cfg.channel_direction_select == 2'h0;
  assign pwm_lvl = (counter_value < ch1_cfg.channel_compare_value) ^ om[0]
    ^ ch1_cfg.channel_polarity_bit;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence s_at_top;
    up_run && counter_value == auto_reload_value;
  endsequence
  sequence s_wrapped;
    counter_value == '0 && event_flags[2];
  endsequence
  sequence s_forced;
    frc && $stable(ch1_cfg);
  endsequence
  property p_wrap;
    s_at_top |=> s_wrapped;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter missed wrap or update");
  property p_pwm;
    pwm_run |=> channel_one_pin_out == $past(pwm_lvl);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level wrong");
  property p_force;
    s_forced [*4] |-> channel_one_pin_out == (om[0] ^ ch1_cfg.channel_polarity_bit);
  endproperty
  a_force: assert property (p_force) else $error("forced level wrong");
  property p_oe;
    clk_en [*3] |-> channel_one_pin_oe == ($past(ch1_cfg.channel_direction_select) == 2'h0);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_sticky;
    clk_en |=> (event_flags & $past(keep)) == $past(keep);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");
  property p_irq;
    clk_en && event_flags[0] && ch1_cfg.channel_irq_enable |-> ##[0:1] irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag gave no interrupt");
  property p_dma_pulse;
    dma_req[0] |=> !dma_req[0];
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("dma request too long");
  property p_dma_flag;
    dma_req[0] |-> ##[0:1] event_flags[2];
  endproperty
  a_dma_flag: assert property (p_dma_flag) else $error("dma without update");
endmodule // tpes_timer_asserts

bind tpes_timer tpes_timer_asserts #(.CNT_W(CNT_W)) chk_u (.clock(clock), .nrst(nrst),
  .clk_en(clk_en), .counter_enable(counter_enable), .single_pulse_enable(single_pulse_enable),
  .count_mode(count_mode), .auto_reload_value(auto_reload_value),
  .prescaler_value(prescaler_value), .slave_function_select(slave_function_select),
  .ch1_cfg(ch1_cfg), .flag_clear(flag_clear), .channel_one_pin_out(channel_one_pin_out),
  .channel_one_pin_oe(channel_one_pin_oe), .counter_value(counter_value),
  .counter_running(counter_running), .event_flags(event_flags), .irq(irq), .dma_req(dma_req));

// ### sim/tpes_enc_model.sv
// Quadrature encoder, also the trigger source on input one.
// Assumes one-cycle step pulses from the bench.
`timescale 1ns/1ps
module tpes_enc_model
(
  input wire logic clock, // Clock
  input wire logic nrst, // Reset
  input wire logic step_fwd, // Forward step
  input wire logic step_back, // Backward step
  output logic phase_a, // Input one
  output logic phase_b // Input two
);
  logic [1:0] pos_r;
  logic [1:0] pos_nxt;
  always_comb
  begin
    pos_nxt = pos_r + {1'b0, step_fwd} - {1'b0, step_back};
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pos_r <= 2'h0;
    else
      pos_r <= pos_nxt;
  end
  // Gray order: one line moves per step, like a real encoder
  assign phase_a = pos_r[1] ^ pos_r[0];
  assign phase_b = pos_r[1];
endmodule // tpes_enc_model

// ### sim/tpes_timer_tb.sv
// Self-checking bench for tpes_timer.
// Assumes tpes_enc_model drives both input pins.
`timescale 1ns/1ps
module tpes_timer_tb;
  import tpes_pkg::*;
  typedef struct {int id; logic [15:0] v;} tpes_note_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic clk_en, counter_enable, single_pulse_enable, fwd, back, pa, pb, p1o, p1e, dir, run, irq;
  tpes_cmode_t count_mode;
  logic [15:0] arr, cnt;
  logic [2:0] sms;
  logic [3:0] flt, flag_clear, flags;
  logic [1:0] dma;
  tpes_chan_cfg_t ch1_cfg;
  tpes_evt_cfg_t evt_cfg;
  logic [31:0] seed = 32'h000145D9;
  tpes_note_t q[$];
  event probe;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  string nm[9] = '{"counter", "pin", "update_flag", "irq", "dir", "run", "oe", "ch_flag", "small"};
  tpes_timer dut_u
  (
    .clock(clock), .nrst(nrst), .clk_en(clk_en), .counter_enable(counter_enable),
    .single_pulse_enable(single_pulse_enable), .count_mode(count_mode),
    .soft_direction_down(1'b0), .auto_reload_value(arr), .prescaler_value(16'h0000),
    .slave_function_select(sms), .trigger_from_input_two(1'b0), .pwm_input_mode(1'b0),
    .input_one_filter_field(flt), .input_two_filter_field(flt), .ch1_cfg(ch1_cfg),
    .ch2_cfg(ch1_cfg), .evt_cfg(evt_cfg), .flag_clear(flag_clear), .channel_one_pin_in(pa),
    .channel_two_pin_in(pb), .channel_one_pin_out(p1o), .channel_one_pin_oe(p1e),
    .channel_two_pin_out(), .channel_two_pin_oe(), .counter_value(cnt),
    .count_direction_bit(dir), .counter_running(run), .event_flags(flags), .irq(irq),
    .dma_req(dma)
  );
  tpes_enc_model enc_u (.clock(clock), .nrst(nrst), .step_fwd(fwd), .step_back(back),
    .phase_a(pa), .phase_b(pb));
  always #10 clock = ~clock;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] pick(int id);
    case (id)
      0: pick = cnt;
      1: pick = {15'h0000, p1o};
      2: pick = {15'h0000, flags[2]};
      3: pick = {15'h0000, irq};
      4: pick = {15'h0000, dir};
      5: pick = {15'h0000, run};
      6: pick = {15'h0000, p1e};
      7: pick = {15'h0000, flags[0]};
      default: pick = {15'h0000, cnt < 16'h0010};
    endcase
  endfunction
  task automatic note(int id, logic [15:0] v);
    q.push_back('{id, v});
    -> probe;
    #1;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic do_reset;
    nrst = 1'b0;
    cyc(20);
    nrst = 1'b1;
    cyc(2);
  endtask
  task automatic clr;
    flag_clear = 4'hF;
    cyc(1);
    flag_clear = 4'h0;
  endtask
  task automatic step(logic b);
    fwd = !b;
    back = b;
    cyc(1);
    fwd = 1'b0;
    back = 1'b0;
    cyc(8);
  endtask
  task automatic wait_cnt(logic [15:0] v);
    for (int i = 0; i < 300 && cnt !== v; i++)
      @(negedge clock);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard: whole run needs well under 3000 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    tpes_note_t n;
    logic [15:0] s;
    forever
    begin
      @(probe);
      n = q.pop_front();
      s = pick(n.id);
      check_count++;
      if (s !== n.v)
      begin
        error_cnt++;
        $display("Error %s: expected %h seen %h", nm[n.id], n.v, s);
      end
    end
  end
  initial
  begin
    logic [15:0] e, c;
    logic cd;
    clk_en = 1'b1;
    counter_enable = 1'b0;
    single_pulse_enable = 1'b0;
    count_mode = tpes_cnt_up;
    arr = 16'h0007;
    sms = 3'h0;
    flt = 4'h0;
    flag_clear = 4'h0;
    fwd = 1'b0;
    back = 1'b0;
    ch1_cfg = '{3'h6, 1'b0, 2'h0, 1'b1, 16'h0005};
    evt_cfg = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    do_reset();
    note(6, 16'h0001);
    counter_enable = 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      count_mode = tpes_cmode_t'(m);
      clr();
      // Center mode starts at the top, where the next step is known to go down
      e = (m == 2) ? 16'h0007 : 16'h0003;
      cd = (m != 0);
      wait_cnt(e);
      for (int k = 0; k < 4; k++)
      begin
        seed = lfsr(seed);
        ch1_cfg.compare_output_mode_field = {2'b11, k[1]};
        ch1_cfg.channel_polarity_bit = k[0];
        ch1_cfg.channel_compare_value = {13'h0000, seed[2:0]};
        repeat (12)
        begin
          c = e;
          if (m == 2 && e == (cd ? 16'h0000 : 16'h0007))
            cd = !cd;
          e = (cd ? e - 16'h0001 : e + 16'h0001) & 16'h0007;
          cyc(1);
          note(0, e);
          note(1, {15'h0000, (c < ch1_cfg.channel_compare_value) ^ k[1] ^ k[0]});
        end
      end
      note(2, 16'h0001);
    end
    for (int k = 0; k < 4; k++)
    begin
      ch1_cfg = '{{2'b10, k[1]}, k[0], 2'h0, 1'b1, 16'h0003};
      clr();
      cyc(9);
      note(1, {15'h0000, k[1] ^ k[0]});
      note(7, 16'h0001);
      note(3, 16'h0001);
    end
    ch1_cfg.channel_irq_enable = 1'b0;
    clr();
    cyc(9);
    note(3, 16'h0000);
    count_mode = tpes_cnt_up;
    single_pulse_enable = 1'b1;
    ch1_cfg = '{3'h7, 1'b0, 2'h0, 1'b1, 16'h0003};
    do_reset();
    cyc(20);
    note(5, 16'h0000);
    note(0, 16'h0000);
    single_pulse_enable = 1'b0;
    arr = 16'h00FF;
    flt = 4'h1;
    for (int m = 1; m < 4; m++)
    begin
      sms = 3'(m);
      do_reset();
      repeat (6) step(1'b0);
      note(0, m == 3 ? 16'h0006 : 16'h0003);
      note(4, 16'h0000);
      repeat (2) step(1'b1);
      note(0, m == 3 ? 16'h0004 : 16'h0002);
      note(4, 16'h0001);
    end
    sms = 3'h6;
    counter_enable = 1'b0;
    do_reset();
    cyc(10);
    note(5, 16'h0000);
    step(1'b0);
    note(5, 16'h0001);
    sms = 3'h5;
    counter_enable = 1'b1;
    do_reset();
    cyc(20);
    note(0, 16'h0000);
    step(1'b0);
    cyc(20);
    note(8, 16'h0000);
    sms = 3'h4;
    do_reset();
    cyc(60);
    note(8, 16'h0000);
    step(1'b0);
    note(8, 16'h0001);
    note(2, 16'h0001);
    give_verdict();
  end
endmodule // tpes_timer_tb
